// [logic/fpt_pkg.sv]
// fpt_pkg.sv: constants for the parameter table and factory defaults
//
// Notes on behaviour
// - 256KB header: id 05h at 15:8, count 00h at 23:16, ones at 31:24.
// - the 256KB header low byte has 7:2 ones, map bit set, end bit set.
// - the 64KB region erase byte flags only type 2, bits 7:4 ones.
// - the 256KB region erase byte flags only type 3, bits 7:4 ones.
// - the 256KB region size is 00FFFFh at 128Mb and 01FFFFh at 256Mb.
// - the 64KB region word top byte is 00h at 128Mb and 01h at 256Mb.
// - every main array byte reads FFh as shipped.
// - the first 16 one-time bytes are random and the rest read FFh.
// - status one, config one and config three hold 00h as shipped.
// - config two non-volatile value is 08h.
// - config four non-volatile value is 10h.
// - the password register holds all ones.
// - the protection register reads FFFFh and all sector bits are 1.
// - the 64KB config header holds id 04h in 15:8 and region count 00h.
package fpt_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_TBL_ADDR = 8'h04;
  localparam logic [7:0] OFF_TBL_DATA = 8'h08;
  localparam logic [7:0] OFF_OTP_ADDR = 8'h0C;
  localparam logic [7:0] OFF_OTP_DATA = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_NV_CFG   = 8'h18;
  localparam logic [7:0] OFF_NV_CFG4  = 8'h1C;
  localparam logic [7:0] OFF_PASS_LO  = 8'h20;
  localparam logic [7:0] OFF_PASS_HI  = 8'h24;
  localparam logic [7:0] OFF_ADV_PROT = 8'h28;
  localparam logic [7:0] OFF_SECT_PROT = 8'h2C;
  localparam logic [7:0] OFF_ARRAY    = 8'h30;
  localparam logic [7:0] OFF_DWORD23  = 8'h40;
  localparam logic [7:0] OFF_DWORD24  = 8'h44;
  localparam logic [7:0] OFF_DWORD25  = 8'h48;
  localparam logic [7:0] OFF_DWORD26  = 8'h4C;

  // ------------------------------------------------------------------
  // reset values of writable fields
  // ------------------------------------------------------------------
  localparam logic       RST_DENSITY  = 1'b0;
  localparam logic [7:0] RST_TBL_ADDR = 8'hA0;
  localparam logic [9:0] RST_OTP_ADDR = 10'h000;

  // ------------------------------------------------------------------
  // parameter table layout
  // ------------------------------------------------------------------
  localparam logic [3:0] TBL_BASE_HI  = 4'hA;
  localparam logic [7:0] TBL_FILL     = 8'hFF;
  localparam logic [7:0] HDR_RFU      = 8'hFF;
  localparam logic [7:0] REGION_COUNT = 8'h00;
  localparam logic [7:0] CFG64_ID     = 8'h04;
  localparam logic [7:0] CFG256_ID    = 8'h05;
  localparam logic [7:0] CFG64_LOW    = 8'hFE;
  localparam logic [7:0] CFG256_LOW   = 8'hFF;
  localparam logic [7:0] ERASE64      = 8'hF2;
  localparam logic [7:0] ERASE256     = 8'hF4;
  localparam logic [23:0] SIZE_128    = 24'h00_FFFF;
  localparam logic [23:0] SIZE_256    = 24'h01_FFFF;

  // ------------------------------------------------------------------
  // factory non-volatile values
  // ------------------------------------------------------------------
  localparam logic [7:0]  ARRAY_ERASED  = 8'hFF;
  localparam logic [7:0]  OTP_ERASED    = 8'hFF;
  localparam int unsigned OTP_RAND_BYTES = 16;
  localparam logic [9:0]  OTP_RAND_END  = 10'h010;
  localparam logic [31:0] OTP_SEED      = 32'h5A3C_96E1; // arbitrary value
  localparam logic [7:0]  NV_STATUS1    = 8'h00;
  localparam logic [7:0]  NV_CFG1       = 8'h00;
  localparam logic [7:0]  NV_CFG2       = 8'h08;
  localparam logic [7:0]  NV_CFG3       = 8'h00;
  localparam logic [7:0]  NV_CFG4       = 8'h10;
  localparam logic [63:0] PASSWORD      = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [15:0] ADV_PROT      = 16'hFFFF;
  localparam logic [31:0] SECT_PROT     = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    FPT_OTP_IDLE = 2'b00,
    FPT_OTP_FILL = 2'b01,
    FPT_OTP_DONE = 2'b11
  } fpt_otp_state_t;

endpackage : fpt_pkg

// [logic/fpt_link_if.sv]
// fpt_link_if.sv: bundle between the register core and its lookups
interface fpt_link_if;
  logic       density;
  logic [7:0] tblAddr;
  logic [7:0] tblByte;
  logic [9:0] otpAddr;
  logic [7:0] otpByte;
  logic       otpReady;

  modport core (output density, tblAddr, otpAddr,
                input  tblByte, otpByte, otpReady);
  modport rom  (input  density, tblAddr, output tblByte);
  modport otp  (input  otpAddr, output otpByte, otpReady);
endinterface : fpt_link_if

// [logic/fpt_param_rom.sv]
// fpt_param_rom.sv: byte view of the sector map tail words
module fpt_param_rom
  import fpt_pkg::*;
(
  // lookup
  fpt_link_if.rom link
);

  logic [31:0] word23;
  logic [31:0] word24;
  logic [31:0] word25;
  logic [31:0] word26;
  logic [23:0] regionSize;
  logic [31:0] selWord;

  // ------------------------------------------------------------------
  // table words
  // ------------------------------------------------------------------
  always_comb begin
    regionSize = link.density ? SIZE_256 : SIZE_128;
    word23 = {HDR_RFU, REGION_COUNT, CFG64_ID, CFG64_LOW};
    word24 = {regionSize, ERASE64};
    word25 = {HDR_RFU, REGION_COUNT, CFG256_ID, CFG256_LOW};
    word26 = {regionSize, ERASE256};
    unique case (link.tblAddr[3:2])
      2'd0: selWord = word23;
      2'd1: selWord = word24;
      2'd2: selWord = word25;
      2'd3: selWord = word26;
    endcase
    // least significant byte at the lowest address
    if (link.tblAddr[7:4] == TBL_BASE_HI) begin
      link.tblByte = selWord[8*link.tblAddr[1:0] +: 8];
    end else begin
      link.tblByte = TBL_FILL;
    end
  end

endmodule : fpt_param_rom

// [logic/fpt_otp_store.sv]
// fpt_otp_store.sv: one-time area with its random leading bytes
module fpt_otp_store
  import fpt_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstLocal_n,
  // lookup
  fpt_link_if.otp   link
);

  fpt_otp_state_t state_ff;
  fpt_otp_state_t nxt_state;
  logic [31:0]    lfsr_ff;
  logic [31:0]    nxt_lfsr;
  logic [3:0]     fillIdx_ff;
  logic [3:0]     nxt_fillIdx;
  logic [7:0]     mem_ff [OTP_RAND_BYTES];

  // ------------------------------------------------------------------
  // fill sequencer: one random byte per cycle after reset
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_lfsr    = lfsr_ff;
    nxt_fillIdx = fillIdx_ff;
    unique case (state_ff)
      FPT_OTP_IDLE: nxt_state = FPT_OTP_FILL;
      FPT_OTP_FILL: begin
        nxt_lfsr    = {lfsr_ff[30:0],
                       lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
        nxt_fillIdx = fillIdx_ff + 4'd1;
        if (fillIdx_ff == 4'hF) begin
          nxt_state = FPT_OTP_DONE;
        end
      end
      FPT_OTP_DONE: nxt_state = FPT_OTP_DONE;
      default:      nxt_state = FPT_OTP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      state_ff   <= FPT_OTP_IDLE;
      lfsr_ff    <= OTP_SEED;
      fillIdx_ff <= 4'h0;
    end else begin
      state_ff   <= nxt_state;
      lfsr_ff    <= nxt_lfsr;
      fillIdx_ff <= nxt_fillIdx;
    end
  end

  // ------------------------------------------------------------------
  // random byte storage
  // ------------------------------------------------------------------
  for (genvar i = 0; i < OTP_RAND_BYTES; i++) begin : gEntry
    logic [7:0] nxt_mem;
    always_comb begin
      nxt_mem = mem_ff[i];
      if (state_ff == FPT_OTP_FILL && fillIdx_ff == 4'(i)) begin
        nxt_mem = lfsr_ff[7:0];
      end
    end
    always_ff @(posedge clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
        mem_ff[i] <= OTP_ERASED;
      end else begin
        mem_ff[i] <= nxt_mem;
      end
    end
  end

  always_comb begin
    link.otpReady = (state_ff == FPT_OTP_DONE);
    if (link.otpAddr < OTP_RAND_END) begin
      link.otpByte = mem_ff[link.otpAddr[3:0]];
    end else begin
      link.otpByte = OTP_ERASED;
    end
  end

endmodule : fpt_otp_store

// [logic/fpt_table_top.sv]
// fpt_table_top.sv: apb register bank for parameter table and defaults
module fpt_table_top
  import fpt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [1:0]  rstSync_ff;
  logic [1:0]  nxt_rstSync;
  logic        rstLocal_n;

  logic        density_ff;
  logic        nxt_density;
  logic [7:0]  tblAddr_ff;
  logic [7:0]  nxt_tblAddr;
  logic [9:0]  otpAddr_ff;
  logic [9:0]  nxt_otpAddr;

  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;

  logic        setupPhase;
  logic        accessDone;
  logic        wrDone;
  logic        rdDone;
  logic [31:0] rdVal;
  logic        rdHit;
  logic [31:0] tblWord;

  fpt_link_if  link ();

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  always_comb begin
    nxt_rstSync = {rstSync_ff[0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= nxt_rstSync;
    end
  end

  assign rstLocal_n = rstSync_ff[1];

  // ------------------------------------------------------------------
  // lookups
  // ------------------------------------------------------------------
  assign link.density = density_ff;
  assign link.tblAddr = tblAddr_ff;
  assign link.otpAddr = otpAddr_ff;

  fpt_param_rom u_rom (
    .link (link.rom)
  );

  fpt_otp_store u_otp (
    .clk        (clk),
    .rstLocal_n (rstLocal_n),
    .link       (link.otp)
  );

  // ------------------------------------------------------------------
  // apb phase decode
  // ------------------------------------------------------------------
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready_ff;
  assign wrDone     = accessDone & pwrite;
  assign rdDone     = accessDone & ~pwrite;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb begin
    rdVal   = 32'h0000_0000;
    rdHit   = 1'b1;
    tblWord = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL:      rdVal = {31'h0000_0000, density_ff};
      OFF_TBL_ADDR:  rdVal = {24'h00_0000, tblAddr_ff};
      OFF_TBL_DATA:  rdVal = {24'h00_0000, link.tblByte};
      OFF_OTP_ADDR:  rdVal = {22'h00_0000, otpAddr_ff};
      OFF_OTP_DATA:  rdVal = {24'h00_0000, link.otpByte};
      OFF_STATUS:    rdVal = {30'h0000_0000, density_ff, link.otpReady};
      OFF_NV_CFG:    rdVal = {NV_CFG3, NV_CFG2, NV_CFG1, NV_STATUS1};
      OFF_NV_CFG4:   rdVal = {24'h00_0000, NV_CFG4};
      OFF_PASS_LO:   rdVal = PASSWORD[31:0];
      OFF_PASS_HI:   rdVal = PASSWORD[63:32];
      OFF_ADV_PROT:  rdVal = {16'h0000, ADV_PROT};
      OFF_SECT_PROT: rdVal = SECT_PROT;
      OFF_ARRAY:     rdVal = {24'h00_0000, ARRAY_ERASED};
      OFF_DWORD23: begin
        tblWord = {HDR_RFU, REGION_COUNT, CFG64_ID, CFG64_LOW};
        rdVal   = tblWord;
      end
      OFF_DWORD24: begin
        tblWord = {(density_ff ? SIZE_256 : SIZE_128), ERASE64};
        rdVal   = tblWord;
      end
      OFF_DWORD25: begin
        tblWord = {HDR_RFU, REGION_COUNT, CFG256_ID, CFG256_LOW};
        rdVal   = tblWord;
      end
      OFF_DWORD26: begin
        tblWord = {(density_ff ? SIZE_256 : SIZE_128), ERASE256};
        rdVal   = tblWord;
      end
      default:       rdHit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // apb answer: ready one cycle after setup, data taken at setup
  // ------------------------------------------------------------------
  always_comb begin
    nxt_pready  = setupPhase;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (setupPhase) begin
      nxt_prdata  = pwrite ? 32'h0000_0000 : rdVal;
      nxt_pslverr = ~rdHit;
    end
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ------------------------------------------------------------------
  // control registers and read side effects
  // ------------------------------------------------------------------
  always_comb begin
    nxt_density = density_ff;
    nxt_tblAddr = tblAddr_ff;
    nxt_otpAddr = otpAddr_ff;
    // density selects the region size fields
    if (wrDone && paddr == OFF_CTRL && pstrb[0]) begin
      nxt_density = pwdata[0];
    end
    if (wrDone && paddr == OFF_TBL_ADDR && pstrb[0]) begin
      nxt_tblAddr = pwdata[7:0];
    end else if (rdDone && paddr == OFF_TBL_DATA) begin
      // byte stream walks the table in address order
      nxt_tblAddr = tblAddr_ff + 8'd1;
    end
    if (wrDone && paddr == OFF_OTP_ADDR) begin
      if (pstrb[0]) begin
        nxt_otpAddr[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        nxt_otpAddr[9:8] = pwdata[9:8];
      end
    end else if (rdDone && paddr == OFF_OTP_DATA) begin
      nxt_otpAddr = otpAddr_ff + 10'd1;
    end
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      density_ff <= RST_DENSITY;
      tblAddr_ff <= RST_TBL_ADDR;
      otpAddr_ff <= RST_OTP_ADDR;
    end else begin
      density_ff <= nxt_density;
      tblAddr_ff <= nxt_tblAddr;
      otpAddr_ff <= nxt_otpAddr;
    end
  end

endmodule : fpt_table_top

// [tb/fpt_host_model.sv]
// fpt_host_model.sv: apb master standing in for the host controller
module fpt_host_model (
  // clock
  input  wire logic        clk,
  // apb request
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // byte lanes used by writes; reads drive no strobe
  logic [3:0] wrStrb;

  initial begin
    wrStrb  = 4'hF;
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
  end

  // one transfer; waits for pready with no limit of its own
  task automatic xfer(input logic [7:0] a, input logic wr,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk);
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    pstrb   <= wr ? wrStrb : 4'h0;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : fpt_host_model

// [tb/fpt_table_checker.sv]
// fpt_table_checker.sv: apb timing and table content assertions
module fpt_table_checker
  import fpt_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb slave
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic densFf;
  logic nxt_densFf;
  logic mapped;
  logic rdDone;

  assign mapped = paddr[1:0] == 2'b00 &&
                  (paddr <= 8'h30 || paddr[7:4] == 4'h4);
  assign rdDone = psel & penable & pready & ~pwrite;

  // ------------------------------------------------------------------
  // density as last written by software
  // ------------------------------------------------------------------
  always_comb begin
    nxt_densFf = densFf;
    if (psel && penable && pready && pwrite && paddr == OFF_CTRL &&
        pstrb[0]) begin
      nxt_densFf = pwdata[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      densFf <= 1'b0;
    end else begin
      densFf <= nxt_densFf;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_ready_access: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without a setup cycle");
  chk_err_unmapped: assert property (rdDone && !mapped |-> pslverr)
    else $error("unmapped read not refused");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer malformed");
  chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata changed without a setup");
  chk_word_cfg64: assert property (
    rdDone && paddr == OFF_DWORD23 |-> prdata == 32'hFF00_04FE)
    else $error("64KB header word wrong");
  chk_region_64: assert property (
    rdDone && paddr == OFF_DWORD24 |-> prdata == {7'h00, densFf, 24'hFF_FFF2})
    else $error("64KB region word wrong");
  chk_word_cfg256: assert property (
    rdDone && paddr == OFF_DWORD25 |-> prdata == 32'hFF00_05FF)
    else $error("256KB header word wrong");
  chk_region_256: assert property (
    rdDone && paddr == OFF_DWORD26 |-> prdata == {7'h00, densFf, 24'hFF_FFF4})
    else $error("256KB region word wrong");
  chk_nv_values: assert property (
    rdDone && paddr == OFF_NV_CFG |-> prdata == 32'h0008_0000)
    else $error("non-volatile config word wrong");
  chk_protect_reg: assert property (
    rdDone && paddr == OFF_ADV_PROT |-> prdata == 32'h0000_FFFF)
    else $error("protection register wrong");
endmodule : fpt_table_checker

bind fpt_table_top fpt_table_checker u_chk (
  .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr)
);

// [tb/testbench.sv]
// testbench.sv: apb tests of parameter table and factory defaults
module testbench
  import fpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_fail;
  int          checks;
  int          cycles;

  fpt_table_top dut (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  fpt_host_model host (
    .clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic        e;
    host.xfer(a, 1'b0, 32'h0000_0000, q, e);
    check(what, q, exp);
    check({what, "_err"}, {31'h0, e}, {31'h0, err});
  endtask : rdChk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic err);
    logic [31:0] q;
    logic        e;
    host.xfer(a, 1'b1, d, q, e);
    check("write_err", {31'h0, e}, {31'h0, err});
  endtask : wr

  initial begin
    clk = 1'b0;
    forever begin
      #4 clk = ~clk;
    end
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 5000) begin
        n_fail++;
        test_done();
      end
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] w [4];
    logic [31:0] q;
    logic [31:0] keep;
    logic        e;
    logic        dens;
    n_fail = 0;
    checks = 0;
    rst_n  = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);

    rdChk("nv_cfg", OFF_NV_CFG, 32'h0008_0000, 1'b0);
    rdChk("nv_cfg4", OFF_NV_CFG4, 32'h0000_0010, 1'b0);
    rdChk("pass_lo", OFF_PASS_LO, 32'hFFFF_FFFF, 1'b0);
    rdChk("pass_hi", OFF_PASS_HI, 32'hFFFF_FFFF, 1'b0);
    rdChk("sect_prot", OFF_SECT_PROT, 32'hFFFF_FFFF, 1'b0);
    rdChk("array", OFF_ARRAY, 32'h0000_00FF, 1'b0);
    wr(OFF_ADV_PROT, 32'h0000_0000, 1'b0);
    rdChk("adv_prot", OFF_ADV_PROT, 32'h0000_FFFF, 1'b0);
    $display("test defaults done");

    for (int d = 0; d < 2; d++) begin
      dens = d[0];
      w[0] = 32'hFF00_04FE;
      w[1] = {7'h00, dens, 24'hFF_FFF2};
      w[2] = 32'hFF00_05FF;
      w[3] = {7'h00, dens, 24'hFF_FFF4};
      wr(OFF_CTRL, {31'h0, dens}, 1'b0);
      wr(OFF_TBL_ADDR, 32'h0000_00A0, 1'b0);
      for (int i = 0; i < 16; i++) begin
        rdChk("tbl_byte", OFF_TBL_DATA, {24'h0, w[i/4][8*(i%4)+:8]},
              1'b0);
      end
      rdChk("word23", OFF_DWORD23, w[0], 1'b0);
      rdChk("word24", OFF_DWORD24, w[1], 1'b0);
      rdChk("word25", OFF_DWORD25, w[2], 1'b0);
      rdChk("word26", OFF_DWORD26, w[3], 1'b0);
    end
    wr(OFF_TBL_ADDR, 32'h0000_00FF, 1'b0);
    rdChk("tbl_fill", OFF_TBL_DATA, 32'h0000_00FF, 1'b0);
    rdChk("tbl_wrap", OFF_TBL_ADDR, 32'h0000_0000, 1'b0);
    $display("test table done");

    q = 32'h0000_0000;
    for (int i = 0; i < 40 && q[0] !== 1'b1; i++) begin
      host.xfer(OFF_STATUS, 1'b0, 32'h0000_0000, q, e);
    end
    check("otp_ready", {31'h0, q[0]}, 32'h0000_0001);
    check("status_dens", {31'h0, q[1]}, 32'h0000_0001);
    wr(OFF_OTP_ADDR, 32'h0000_000E, 1'b0);
    host.xfer(OFF_OTP_DATA, 1'b0, 32'h0000_0000, keep, e);
    check("otp_hi_zero", {8'h00, keep[31:8]}, 32'h0000_0000);
    host.xfer(OFF_OTP_DATA, 1'b0, 32'h0000_0000, q, e);
    rdChk("otp_16", OFF_OTP_DATA, 32'h0000_00FF, 1'b0);
    rdChk("otp_17", OFF_OTP_DATA, 32'h0000_00FF, 1'b0);
    rdChk("otp_addr", OFF_OTP_ADDR, 32'h0000_0012, 1'b0);
    // the random bytes are fixed once filled
    wr(OFF_OTP_ADDR, 32'h0000_000E, 1'b0);
    rdChk("otp_stable", OFF_OTP_DATA, keep, 1'b0);
    wr(OFF_OTP_ADDR, 32'h0000_03FF, 1'b0);
    rdChk("otp_last", OFF_OTP_DATA, 32'h0000_00FF, 1'b0);
    // only lane 1 written: the low address bits keep their wrapped zero
    host.wrStrb = 4'h2;
    wr(OFF_OTP_ADDR, 32'h0000_03FF, 1'b0);
    host.wrStrb = 4'hF;
    rdChk("otp_strb", OFF_OTP_ADDR, 32'h0000_0300, 1'b0);
    $display("test otp done");

    rdChk("unmapped_rd", 8'h34, 32'h0000_0000, 1'b1);
    wr(8'h50, 32'h0000_0000, 1'b1);
    rdChk("after_err", OFF_NV_CFG4, 32'h0000_0010, 1'b0);
    $display("test errors done");
    test_done();
  end
endmodule : testbench
